// file: design/swt_stopwatch.sv
// Purpose: two-digit bcd stopwatch with 100/10/1 Hz event flags
// Assumes: 8-bit register port, read data one cycle after read strobe
// Notes: 100 Hz steps derived from the 256 Hz tick by fraction accumulation
// Functional notes
// - run bit D0 gates counting, resets 0
// - writing 1 to D1 clears count
// - enable bits D6/D5/D4, reset disabled
// - event flags set regardless of enables
// - write 1 clears flag, reset 0
// - request only when flag and enable
// - priority field D3:D2, resets 00
// - stop takes effect at next 256 Hz tick
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps
// tick spacing is a parameter only so a bench can shorten it; keep the default in silicon
module swt_stopwatch #(
	parameter int TICK_CYCLES = swt_pkg::TICK_CYCLES
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [23:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	output logic [7:0] rdata_o,
	output logic [1:0] sw_priority_o,
	output logic sw_request_o,
	output logic irq_o
);
	swt_tick_if tick_bus ();

	swt_tick_div #(
		.TICK_CYCLES(TICK_CYCLES)
	) u_div (
		.clock_i(clock_i),
		.resetn_i(resetn_i),
		.tick_if(tick_bus)
	);

	logic run_stop_bit_reg;
	logic run_stop_bit_next;
	logic run_live_reg;
	logic run_live_next;
	logic [1:0] prio_reg;
	logic [1:0] prio_next;
	logic [2:0] enable_reg;
	logic [2:0] enable_next;
	logic [2:0] flag_reg;
	logic [2:0] flag_next;
	logic [3:0] tenths_reg;
	logic [3:0] tenths_next;
	logic [3:0] hundredths_reg;
	logic [3:0] hundredths_next;
	logic [7:0] frac_reg;
	logic [7:0] frac_next;
	logic [2:0] status_reg;
	logic [2:0] status_next;
	logic [2:0] status_en_reg;
	logic [2:0] status_en_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic request_reg;
	logic request_next;
	logic irq_reg;
	logic irq_next;

	// events raised this cycle, order: 1 Hz, 10 Hz, 100 Hz in bits 0..2
	logic [2:0] events;
	logic [8:0] frac_sum;

	function automatic logic [2:0] pick3(input logic [7:0] b);
		pick3 = b[swt_pkg::HUNDRED_HZ_POS:swt_pkg::ONE_HZ_POS];
	endfunction : pick3

	function automatic logic [7:0] place3(input logic [2:0] v);
		place3 = {1'b0, v, 4'h0};
	endfunction : place3

	logic wr_control;
	logic wr_prio;
	logic wr_enable;
	logic wr_factor;
	logic wr_irq_en;
	logic wr_irq_clr;
	assign wr_control = write_i && addr_i == swt_pkg::ADDR_CONTROL;
	assign wr_prio = write_i && addr_i == swt_pkg::ADDR_PRIORITY;
	assign wr_enable = write_i && addr_i == swt_pkg::ADDR_ENABLE;
	assign wr_factor = write_i && addr_i == swt_pkg::ADDR_FACTOR;
	assign wr_irq_en = write_i && addr_i == swt_pkg::ADDR_IRQ_ENABLE;
	assign wr_irq_clr = write_i && addr_i == swt_pkg::ADDR_IRQ_CLEAR;

	// counting and control
	always_comb begin
		run_stop_bit_next = run_stop_bit_reg;
		run_live_next = run_live_reg;
		tenths_next = tenths_reg;
		hundredths_next = hundredths_reg;
		frac_next = frac_reg;
		events = swt_pkg::EVENTS_NONE;
		frac_sum = {1'b0, frac_reg} + {1'b0, swt_pkg::FRAC_STEP};
		if (wr_control) begin
			run_stop_bit_next = wdata_i[swt_pkg::RUN_POS];
		end
		if (tick_bus.tick) begin
			// stopping lags to the tick boundary so a last step may still land
			run_live_next = run_stop_bit_reg;
			if (run_live_reg) begin
				frac_next = frac_sum[7:0];
				// 100 of every 256 ticks advance the hundredths digit
				if (frac_sum[8]) begin
					events[2] = 1'b1;
					if (hundredths_reg == swt_pkg::DIGIT_MAX) begin
						hundredths_next = 4'h0;
						events[1] = 1'b1;
						if (tenths_reg == swt_pkg::DIGIT_MAX) begin
							tenths_next = 4'h0;
							events[0] = 1'b1;
						end else begin
							tenths_next = tenths_reg + 4'h1;
						end
					end else begin
						hundredths_next = hundredths_reg + 4'h1;
					end
				end
			end
		end
		if (wr_control && wdata_i[swt_pkg::CLEAR_POS]) begin
			tenths_next = 4'h0;
			hundredths_next = 4'h0;
			frac_next = 8'h00;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			run_stop_bit_reg <= 1'b0;
			run_live_reg <= 1'b0;
			tenths_reg <= 4'h0;
			hundredths_reg <= 4'h0;
			frac_reg <= 8'h00;
		end else begin
			run_stop_bit_reg <= run_stop_bit_next;
			run_live_reg <= run_live_next;
			tenths_reg <= tenths_next;
			hundredths_reg <= hundredths_next;
			frac_reg <= frac_next;
		end
	end

	// flags, enables, priority, interrupt
	always_comb begin
		prio_next = prio_reg;
		enable_next = enable_reg;
		flag_next = flag_reg;
		status_next = status_reg;
		status_en_next = status_en_reg;
		if (wr_prio) begin
			prio_next = wdata_i[swt_pkg::PRIO_LO_POS+1:swt_pkg::PRIO_LO_POS];
		end
		if (wr_enable) begin
			enable_next = pick3(wdata_i);
		end
		if (wr_factor) begin
			flag_next = flag_reg & ~pick3(wdata_i);
		end
		if (wr_irq_en) begin
			status_en_next = wdata_i[2:0];
		end
		if (wr_irq_clr) begin
			status_next = status_reg & ~wdata_i[2:0];
		end
		// set wins over a same-cycle clear
		flag_next = flag_next | events;
		status_next = status_next | events;
		request_next = |(flag_next & enable_next);
		irq_next = |(status_next & status_en_next);
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prio_reg <= swt_pkg::PRIO_RESET;
			enable_reg <= swt_pkg::EVENTS_NONE;
			flag_reg <= swt_pkg::EVENTS_NONE;
			status_reg <= swt_pkg::EVENTS_NONE;
			status_en_reg <= swt_pkg::EVENTS_NONE;
			request_reg <= 1'b0;
			irq_reg <= 1'b0;
		end else begin
			prio_reg <= prio_next;
			enable_reg <= enable_next;
			flag_reg <= flag_next;
			status_reg <= status_next;
			status_en_reg <= status_en_next;
			request_reg <= request_next;
			irq_reg <= irq_next;
		end
	end

	// read port; clear register and the write-only bit read as zero
	always_comb begin
		rdata_next = swt_pkg::RESET_BYTE;
		if (read_i) begin
			unique case (addr_i)
				swt_pkg::ADDR_PRIORITY: rdata_next = {4'h0, prio_reg, 2'h0};
				swt_pkg::ADDR_ENABLE: rdata_next = place3(enable_reg);
				swt_pkg::ADDR_FACTOR: rdata_next = place3(flag_reg);
				swt_pkg::ADDR_CONTROL: rdata_next = {7'h00, run_stop_bit_reg};
				swt_pkg::ADDR_COUNT: rdata_next = {tenths_reg, hundredths_reg};
				swt_pkg::ADDR_IRQ_STATUS: rdata_next = {5'h00, status_reg};
				swt_pkg::ADDR_IRQ_ENABLE: rdata_next = {5'h00, status_en_reg};
				default: rdata_next = swt_pkg::RESET_BYTE;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_reg <= swt_pkg::RESET_BYTE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign rdata_o = rdata_reg;
	assign sw_priority_o = prio_reg;
	assign sw_request_o = request_reg;
	assign irq_o = irq_reg;
endmodule : swt_stopwatch

// file: design/swt_pkg.sv
// Purpose: shared constants for the stopwatch timer block
// Assumes: 100 MHz system clock, 8-bit register port
// Notes: offsets are byte addresses of the register port
package swt_pkg;
	localparam logic [23:0] ADDR_PRIORITY = 24'h00FF20;
	localparam logic [23:0] ADDR_ENABLE = 24'h00FF22;
	localparam logic [23:0] ADDR_FACTOR = 24'h00FF24;
	localparam logic [23:0] ADDR_CONTROL = 24'h00FF42;
	localparam logic [23:0] ADDR_COUNT = 24'h00FF43;
	localparam logic [23:0] ADDR_IRQ_STATUS = 24'h00FF50;
	localparam logic [23:0] ADDR_IRQ_ENABLE = 24'h00FF51;
	localparam logic [23:0] ADDR_IRQ_CLEAR = 24'h00FF52;
	localparam int RUN_POS = 0;
	localparam int CLEAR_POS = 1;
	localparam int PRIO_LO_POS = 2;
	localparam int ONE_HZ_POS = 4;
	localparam int TEN_HZ_POS = 5;
	localparam int HUNDRED_HZ_POS = 6;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [1:0] PRIO_RESET = 2'h0;
	localparam logic [2:0] EVENTS_NONE = 3'h0;
	localparam logic [3:0] DIGIT_MAX = 4'h9;
	localparam int CLOCK_HZ = 100000000;
	localparam int TICK_HZ = 256;
	localparam int TICK_CYCLES = CLOCK_HZ / TICK_HZ;
	localparam int DIV_WIDTH = 19;
	localparam logic [7:0] FRAC_STEP = 8'h64;
endpackage : swt_pkg

// file: design/swt_tick_if.sv
// Purpose: carries the 256 Hz tick between divider and core
// Assumes: single clock domain
// Notes: tick is a one-cycle enable pulse
`timescale 1ns/10ps
interface swt_tick_if;
	logic tick;
	modport source (output tick);
	modport sink (input tick);
endinterface : swt_tick_if

// file: design/swt_tick_div.sv
// Purpose: divides the system clock to a 256 Hz enable pulse
// Assumes: clock_i at the package rate
// Notes: free running from reset
`timescale 1ns/10ps
module swt_tick_div #(
	parameter int TICK_CYCLES = swt_pkg::TICK_CYCLES
) (
	input wire logic clock_i,
	input wire logic resetn_i,
	swt_tick_if.source tick_if
);
	logic [swt_pkg::DIV_WIDTH-1:0] count_reg;
	logic [swt_pkg::DIV_WIDTH-1:0] count_next;
	logic tick_reg;
	logic tick_next;

	always_comb begin
		tick_next = 1'b0;
		count_next = count_reg + 1'b1;
		if (count_reg == swt_pkg::DIV_WIDTH'(TICK_CYCLES - 1)) begin
			count_next = '0;
			tick_next = 1'b1;
		end
	end

	always_ff @(posedge clock_i or negedge resetn_i) begin
		if (!resetn_i) begin
			count_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			count_reg <= count_next;
			tick_reg <= tick_next;
		end
	end

	assign tick_if.tick = tick_reg;
endmodule : swt_tick_div

// file: tb/swt_asserts.sv
// Purpose: port assertions for the stopwatch
// Assumes: one clock, async low reset
// Notes: bound to the stopwatch below
`timescale 1ns/10ps
module swt_asserts (
	input wire logic clock_i,
	input wire logic resetn_i,
	input wire logic [23:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	input wire logic [7:0] rdata_o,
	input wire logic [1:0] sw_priority_o,
	input wire logic sw_request_o,
	input wire logic irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!resetn_i);
	a_prio_write: assert property (write_i && addr_i == 24'h00FF20
		|=> sw_priority_o == $past(wdata_i[3:2])) else $error("priority not stored");
	a_prio_hold: assert property (!(write_i && addr_i == 24'h00FF20)
		|=> $stable(sw_priority_o)) else $error("priority moved");
	a_prio_read: assert property (read_i && addr_i == 24'h00FF20
		|=> rdata_o == {4'h0, sw_priority_o, 2'h0}) else $error("priority read");
	a_ctrl_read: assert property (read_i && addr_i == 24'h00FF42
		|=> rdata_o[7:1] == 7'h00) else $error("control read");
	a_bcd_read: assert property (read_i && addr_i == 24'h00FF43
		|=> rdata_o[7:4] <= 4'h9 && rdata_o[3:0] <= 4'h9) else $error("count not bcd");
	a_enable_gate: assert property (write_i && addr_i == 24'h00FF22 && wdata_i[6:4] == 3'h0
		|=> !sw_request_o) else $error("request without enable");
	a_enable_read: assert property (read_i && addr_i == 24'h00FF22
		|=> rdata_o[7] == 1'b0 && rdata_o[3:0] == 4'h0) else $error("enable read");
	a_reset_quiet: assert property ($rose(resetn_i) |-> !sw_request_o && !irq_o)
		else $error("request out of reset");
endmodule : swt_asserts
bind swt_stopwatch swt_asserts chk (.clock_i(clock_i), .resetn_i(resetn_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
	.sw_priority_o(sw_priority_o), .sw_request_o(sw_request_o), .irq_o(irq_o));

// file: tb/swt_cpu_model.sv
// Purpose: cpu side of the register port
// Assumes: strobes are one cycle, read data the cycle after
// Notes: the bench calls its tasks
`timescale 1ns/10ps
module swt_cpu_model (
	input wire logic clock_i,
	output logic [23:0] addr_o = 24'h000000,
	output logic [7:0] wdata_o = 8'h00,
	output logic write_o = 1'b0,
	output logic read_o = 1'b0,
	input wire logic [7:0] rdata_i
);
	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		wdata_o <= d;
		write_o <= 1'b1;
		@(posedge clock_i);
		write_o <= 1'b0;
	endtask : wr
	task automatic rd(input logic [23:0] a, output logic [7:0] d);
		@(posedge clock_i);
		addr_o <= a;
		read_o <= 1'b1;
		@(posedge clock_i);
		read_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask : rd
endmodule : swt_cpu_model

// file: tb/tb_stopwatch_timer_bcd.sv
// Purpose: self-checking bench for the stopwatch
// Assumes: cpu model drives the register port
// Notes: tick spacing shortened through the top parameter to keep the run short
`timescale 1ns/10ps
module tb_stopwatch_timer_bcd;
	localparam int TB_TICK = 64;
	logic clock_i = 1'b0;
	logic resetn_i = 1'b0;
	logic [23:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic write;
	logic read;
	logic req;
	logic irq;
	logic [1:0] prio;
	int failures = 0;
	int total_checks = 0;
	initial begin
		forever #5 clock_i = ~clock_i;
	end
	swt_cpu_model cpu (.clock_i(clock_i), .addr_o(addr), .wdata_o(wdata), .write_o(write),
		.read_o(read), .rdata_i(rdata));
	swt_stopwatch #(.TICK_CYCLES(TB_TICK)) DUT (.clock_i(clock_i), .resetn_i(resetn_i),
		.addr_i(addr), .wdata_i(wdata),
		.write_i(write), .read_i(read), .rdata_o(rdata), .sw_priority_o(prio),
		.sw_request_o(req), .irq_o(irq));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic rc(input string n, input logic [23:0] a, input logic [7:0] e);
		logic [7:0] d;
		cpu.rd(a, d);
		chk(n, e, d);
	endtask : rc
	task automatic t_reset;
		rc("priority", 24'h00FF20, 8'h00);
		rc("enable", 24'h00FF22, 8'h00);
		rc("factor", 24'h00FF24, 8'h00);
		rc("control", 24'h00FF42, 8'h00);
		rc("count", 24'h00FF43, 8'h00);
		rc("unmapped", 24'h00FF30, 8'h00);
	endtask : t_reset
	task automatic t_regs;
		cpu.wr(24'h00FF20, 8'hFF);
		rc("priority", 24'h00FF20, 8'h0C);
		chk("priority pin", 8'h03, {6'h00, prio});
		cpu.wr(24'h00FF22, 8'hFF);
		rc("enable", 24'h00FF22, 8'h70);
		cpu.wr(24'h00FF24, 8'h70);
		rc("factor", 24'h00FF24, 8'h00);
		cpu.wr(24'h00FF42, 8'h02);
		rc("control", 24'h00FF42, 8'h00);
	endtask : t_regs
	task automatic t_event;
		cpu.wr(24'h00FF20, 8'h04);
		cpu.wr(24'h00FF22, 8'h70);
		cpu.wr(24'h00FF42, 8'h02);
		cpu.wr(24'h00FF42, 8'h01);
		cpu.wr(24'h00FF51, 8'h04);
		for (int i = 0; i < 6 * TB_TICK && req !== 1'b1; i++) begin
			@(posedge clock_i);
			#1;
		end
		chk("request", 8'h01, {7'h00, req});
		rc("factor", 24'h00FF24, 8'h40);
		rc("count", 24'h00FF43, 8'h01);
		chk("irq", 8'h01, {7'h00, irq});
		cpu.wr(24'h00FF24, 8'h40);
		repeat (2) @(posedge clock_i);
		#1;
		chk("request cleared", 8'h00, {7'h00, req});
		cpu.wr(24'h00FF52, 8'h07);
		repeat (2) @(posedge clock_i);
		#1;
		chk("irq cleared", 8'h00, {7'h00, irq});
		cpu.wr(24'h00FF22, 8'h00);
		cpu.wr(24'h00FF42, 8'h00);
		// stop lags one tick, so let the last step land before clearing
		repeat (3 * TB_TICK) @(posedge clock_i);
		cpu.wr(24'h00FF42, 8'h02);
		rc("count cleared", 24'h00FF43, 8'h00);
	endtask : t_event
	task automatic report_and_stop;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (5) @(posedge clock_i);
		resetn_i <= 1'b1;
		t_reset();
		t_regs();
		t_event();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge clock_i);
		failures++;
		report_and_stop();
	end
endmodule : tb_stopwatch_timer_bcd
